// ---- rtl/icf_capability_fields.sv ----
// Implementation choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module icf_capability_fields
  import icf_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output var  logic [31:0] readdata,
  output var  logic        waitrequest,
  output var  logic        configLocked,
  output var  logic        msixActive
);

  // ---------------------------------------------------------------------
  // Run-time settings and bus decode signals
  // ---------------------------------------------------------------------
  icf_config_t cfg;
  logic        busy;
  logic        reqLive;
  logic [3:0]  wordIndex;
  logic        mapped;
  logic [31:0] next_readdata;
  logic [31:0] mergedWrite;
  logic [31:0] currentWord;

  // Word index of a byte address; the two low address bits are ignored.
  function automatic logic [3:0] word_of(input logic [5:0] byteAddr);
    word_of = byteAddr[5:2];
  endfunction

  // Reserved multiple-message codes are clamped to the largest legal one.
  function automatic logic [2:0] legal_code(input logic [2:0] code);
    if (code > MSI_CODE_MAX) begin
      legal_code = MSI_CODE_MAX;
    end else begin
      legal_code = code;
    end
  endfunction

  assign wordIndex = word_of(address);
  assign reqLive   = (read || write) && !busy;
  assign mapped    = (wordIndex <= PM_CONFIG_OFS);

  // ---------------------------------------------------------------------
  // Read-back words
  // ---------------------------------------------------------------------
  always_comb begin
    currentWord = UNMAPPED_READ;
    if (wordIndex == MSI_CTRL_OFS) begin
      currentWord[7:0] = MSI_ID;
      currentWord[MSI_CODE_MSB:MSI_CODE_LSB] = cfg.vectorCode;
    end else if (wordIndex == MSIX_CTRL_OFS) begin
      currentWord[7:0] = MSIX_ID;
      currentWord[MSIX_NEXT_LSB +: 8] = cfg.msixNext;
      if (cfg.msixEnable) begin
        currentWord[16 +: 11] = cfg.tableSize;
      end
    end else if (wordIndex == MSIX_TABLE_OFS) begin
      if (cfg.msixEnable) begin
        currentWord = {cfg.tableOffset, cfg.tableBar};
      end
    end else if (wordIndex == MSIX_PENDING_OFS) begin
      if (cfg.msixEnable) begin
        currentWord = {cfg.pendingOffset, cfg.pendingBar};
      end
    end else if (wordIndex == PM_HEADER_OFS) begin
      currentWord[7:0]              = cfg.pmId;
      currentWord[PM_NEXT_LSB +: 8] = cfg.pmNext;
    end else if (wordIndex == CFG_CONTROL_OFS) begin
      currentWord[MSIX_EN_BIT] = cfg.msixEnable;
      currentWord[LOCK_BIT]    = configLocked;
    end else if (wordIndex == MSI_CONFIG_OFS) begin
      currentWord[2:0] = cfg.vectorCode;
    end else if (wordIndex == MSIX_CONFIG_OFS) begin
      currentWord[7:0] = cfg.msixNext;
    end else if (wordIndex == MSIX_TBLCFG_OFS) begin
      currentWord = {cfg.tableOffset, cfg.tableBar};
    end else if (wordIndex == MSIX_PNDCFG_OFS) begin
      currentWord = {cfg.pendingOffset, cfg.pendingBar};
    end else if (wordIndex == PM_CONFIG_OFS) begin
      currentWord[MSIX_SIZE_MSB:0]  = cfg.tableSize;
      currentWord[23:16]            = cfg.pmId;
      currentWord[31:24]            = cfg.pmNext;
    end
  end

  always_comb begin
    integer i;
    i           = 0;
    mergedWrite = currentWord;
    for (i = 0; i < 4; i = i + 1) begin
      if (byteenable[i]) begin
        mergedWrite[i*8 +: 8] = writedata[i*8 +: 8];
      end
    end
  end

  assign next_readdata = mapped ? currentWord : UNMAPPED_READ;

  // ---------------------------------------------------------------------
  // Bus handshake: one wait cycle, answer on the second edge
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy        <= 1'b0;
      waitrequest <= 1'b1;
    end else if (clkEn) begin
      if (reqLive) begin
        busy        <= 1'b1;
        waitrequest <= 1'b0;
      end else begin
        busy        <= 1'b0;
        waitrequest <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      readdata <= UNMAPPED_READ;
    end else if (clkEn && reqLive && read) begin
      readdata <= next_readdata;
    end
  end

  // ---------------------------------------------------------------------
  // Configuration store
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg.vectorCode    <= MSI_CODE_RST;
      cfg.msixEnable    <= 1'b0;
      cfg.msixNext      <= MSIX_NEXT_RST;
      cfg.tableBar      <= BAR_INDEX_RST;
      cfg.tableOffset   <= ARRAY_OFFSET_RST;
      cfg.pendingBar    <= BAR_INDEX_RST;
      cfg.pendingOffset <= ARRAY_OFFSET_RST;
      cfg.tableSize     <= TABLE_SIZE_RST;
      cfg.pmId          <= PM_ID_RST;
      cfg.pmNext        <= PM_NEXT_RST;
      configLocked      <= 1'b0;
    end else if (clkEn && write && busy && !waitrequest) begin
      // A write lands only at the edge that completes the transfer.
      // Capability words ignore writes; settings freeze once locked.
      if (wordIndex == CFG_CONTROL_OFS && !configLocked) begin
        cfg.msixEnable <= mergedWrite[MSIX_EN_BIT];
        configLocked   <= mergedWrite[LOCK_BIT];
      end else if (wordIndex == MSI_CONFIG_OFS && !configLocked) begin
        // Reserved codes never reach the field.
        cfg.vectorCode <= legal_code(mergedWrite[2:0]);
      end else if (wordIndex == MSIX_CONFIG_OFS && !configLocked) begin
        cfg.msixNext <= mergedWrite[7:0];
      end else if (wordIndex == MSIX_TBLCFG_OFS && !configLocked) begin
        cfg.tableBar    <= mergedWrite[2:0];
        cfg.tableOffset <= mergedWrite[31:3];
      end else if (wordIndex == MSIX_PNDCFG_OFS && !configLocked) begin
        cfg.pendingBar    <= mergedWrite[2:0];
        cfg.pendingOffset <= mergedWrite[31:3];
      end else if (wordIndex == PM_CONFIG_OFS && !configLocked) begin
        cfg.tableSize <= mergedWrite[MSIX_SIZE_MSB:0];
        cfg.pmId      <= mergedWrite[23:16];
        cfg.pmNext    <= mergedWrite[31:24];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      msixActive <= 1'b0;
    end else if (clkEn) begin
      msixActive <= cfg.msixEnable;
    end
  end

endmodule

`default_nettype wire

// ---- rtl/icf_pkg.sv ----
package icf_pkg;

  // ---------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------
  localparam logic [3:0] MSI_CTRL_OFS     = 4'h0;
  localparam logic [3:0] MSIX_CTRL_OFS    = 4'h1;
  localparam logic [3:0] MSIX_TABLE_OFS   = 4'h2;
  localparam logic [3:0] MSIX_PENDING_OFS = 4'h3;
  localparam logic [3:0] PM_HEADER_OFS    = 4'h4;
  localparam logic [3:0] CFG_CONTROL_OFS  = 4'h5;
  localparam logic [3:0] MSI_CONFIG_OFS   = 4'h6;
  localparam logic [3:0] MSIX_CONFIG_OFS  = 4'h7;
  localparam logic [3:0] MSIX_TBLCFG_OFS  = 4'h8;
  localparam logic [3:0] MSIX_PNDCFG_OFS  = 4'h9;
  localparam logic [3:0] PM_CONFIG_OFS    = 4'hA;

  // ---------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------
  localparam int MSI_CODE_LSB   = 17;
  localparam int MSI_CODE_MSB   = 19;
  localparam int MSIX_NEXT_LSB  = 8;
  localparam int PM_NEXT_LSB    = 8;
  localparam int LOCK_BIT       = 1;
  localparam int MSIX_EN_BIT    = 0;
  localparam int MSIX_SIZE_MSB  = 10;

  // ---------------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------------
  localparam logic [2:0]  MSI_CODE_MAX       = 3'h5;
  localparam logic [2:0]  MSI_CODE_RST       = 3'h0;
  localparam logic [7:0]  MSIX_NEXT_RST      = 8'h00;
  localparam logic [2:0]  BAR_INDEX_RST      = 3'h0;
  localparam logic [28:0] ARRAY_OFFSET_RST   = 29'h00000000;
  localparam logic [10:0] TABLE_SIZE_RST     = 11'h000;
  localparam logic [7:0]  PM_ID_RST          = 8'h01;
  localparam logic [7:0]  PM_NEXT_RST        = 8'h00;
  localparam logic [7:0]  MSIX_ID            = 8'h11;
  localparam logic [7:0]  MSI_ID             = 8'h05;
  localparam logic [31:0] UNMAPPED_READ      = 32'h00000000;

  typedef struct packed {
    logic [2:0]  vectorCode;
    logic        msixEnable;
    logic [7:0]  msixNext;
    logic [2:0]  tableBar;
    logic [28:0] tableOffset;
    logic [2:0]  pendingBar;
    logic [28:0] pendingOffset;
    logic [10:0] tableSize;
    logic [7:0]  pmId;
    logic [7:0]  pmNext;
  } icf_config_t;

endpackage

// ---- tb/icf_capability_fields_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module icf_capability_fields_sva
  import icf_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire logic [5:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic        configLocked,
  input wire logic        msixActive
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic       rdAns;
  logic [3:0] word;
  assign rdAns = read && !waitrequest;
  assign word  = address[5:2];
  a_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("Answer without request.");
  a_wait_one: assert property (clkEn && !waitrequest |=> waitrequest)
    else $error("Answer held too long.");
  a_code_legal: assert property (rdAns && word == MSI_CTRL_OFS |->
    readdata[19:17] <= MSI_CODE_MAX && readdata[7:0] == MSI_ID)
    else $error("Bad vector code word.");
  a_table_gate: assert property (rdAns && word == MSIX_TABLE_OFS &&
    !msixActive |-> readdata == 32'h00000000) else $error("Table not gated.");
  a_pend_gate: assert property (rdAns && word == MSIX_PENDING_OFS &&
    !msixActive |-> readdata == 32'h00000000) else $error("Pending not gated.");
  a_size_gate: assert property (rdAns && word == MSIX_CTRL_OFS &&
    !msixActive |-> readdata[26:16] == 11'h000) else $error("Size not gated.");
  a_lock_hold: assert property (configLocked |=> configLocked)
    else $error("Lock dropped.");
  a_unmapped_zero: assert property (rdAns && word > PM_CONFIG_OFS |->
    readdata == UNMAPPED_READ) else $error("Unmapped word not zero.");
  a_reset_state: assert property (disable iff (1'b0) rst && clkEn |=>
    waitrequest && !configLocked && !msixActive) else $error("Bad reset.");
endmodule
bind icf_capability_fields icf_capability_fields_sva i_sva (
  .sys_clk(sys_clk), .rst(rst), .clkEn(clkEn), .address(address),
  .read(read), .write(write), .readdata(readdata),
  .waitrequest(waitrequest), .configLocked(configLocked),
  .msixActive(msixActive));
`default_nettype wire

// ---- tb/icf_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module icf_host_model
(
  input  wire logic        sys_clk,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  output var  logic [5:0]  address,
  output var  logic        read,
  output var  logic        write,
  output var  logic [31:0] writedata,
  output var  logic [3:0]  byteenable
);
  initial begin
    address = 6'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h00000000;
    byteenable = 4'hF;
  end
  task automatic xfer(input logic wr, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= wr ? d : ~writedata;
    do @(posedge sys_clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    writedata <= ~writedata;
  endtask
endmodule
`default_nettype wire

// ---- tb/interrupt_pm_capability_fields_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module interrupt_pm_capability_fields_tb_top
  import icf_pkg::*;
;
  logic        sys_clk, rst, read, write, waitrequest, configLocked, msixActive;
  logic        clkEn = 1'b1;
  logic [5:0]  address;
  logic [31:0] writedata, readdata;
  logic [3:0]  byteenable;
  int          fails, checks, cycles;
  icf_capability_fields i_icf_capability_fields (.sys_clk(sys_clk),
    .rst(rst), .clkEn(clkEn), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest),
    .configLocked(configLocked), .msixActive(msixActive));
  icf_host_model i_icf_host_model (.sys_clk(sys_clk), .readdata(readdata),
    .waitrequest(waitrequest), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    i_icf_host_model.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    i_icf_host_model.xfer(1'b0, a, 32'h00000000, q);
    check(q, exp);
  endtask
  task automatic testCodes();
    logic [2:0] e;
    for (int c = 0; c < 8; c++) begin
      e = (c > 5) ? MSI_CODE_MAX : 3'(c);
      wr(6'h18, 32'(c));
      rd(6'h00, {12'h000, e, 9'h000, MSI_ID});
      rd(6'h00, {12'h000, e, 9'h000, MSI_ID});
    end
    $display("test codes done");
  endtask
  task automatic testMsix();
    wr(6'h1C, 32'h000000A4);
    wr(6'h20, 32'h91A2B3C5);
    wr(6'h24, 32'h55E6F77B);
    wr(6'h28, 32'h9C0107FF);
    rd(6'h08, 32'h00000000);
    rd(6'h0C, 32'h00000000);
    rd(6'h04, {16'h0000, 8'hA4, MSIX_ID});
    rd(6'h10, 32'h00009C01);
    wr(6'h14, 32'h00000001);
    rd(6'h08, 32'h91A2B3C5);
    rd(6'h0C, 32'h55E6F77B);
    rd(6'h04, {5'h00, 11'h7FF, 8'hA4, MSIX_ID});
    check({31'h00000000, msixActive}, 32'h00000001);
    $display("test msix done");
  endtask
  task automatic testLock();
    for (int a = 0; a < 5; a++) wr(6'(a * 4), 32'hFFFFFFFF);
    rd(6'h00, {12'h000, 3'h5, 9'h000, MSI_ID});
    rd(6'h08, 32'h91A2B3C5);
    wr(6'h14, 32'h00000003);
    wr(6'h18, 32'h00000001);
    wr(6'h14, 32'h00000000);
    rd(6'h00, {12'h000, 3'h5, 9'h000, MSI_ID});
    rd(6'h10, 32'h00009C01);
    check({31'h00000000, configLocked}, 32'h00000001);
    wr(6'h2C, 32'h12345678);
    rd(6'h2C, UNMAPPED_READ);
    rd(6'h3C, UNMAPPED_READ);
    $display("test lock done");
  endtask
  task automatic testFreeze();
    fork
      rd(6'h08, 32'h91A2B3C5);
      begin
        @(posedge sys_clk);
        clkEn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check({31'h00000000, waitrequest}, 32'h00000001);
        clkEn <= 1'b1;
      end
    join
    $display("test freeze done");
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      results();
    end
  end
  initial begin
    rst = 1'b1;
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rd(6'h10, {24'h000000, PM_ID_RST});
    testCodes();
    testMsix();
    testLock();
    testFreeze();
    results();
  end
endmodule
`default_nettype wire
